// *** verilog/iamc_top.v ***
// Purpose: two-wire slave interface and conversion-mode sequencer
// Assumes: analog core handshakes on clk_sys_in; bus pins asynchronous
// Notes: clock line is input only; sda is open drain via sda_oe_out
`timescale 1ns/1ps
`include "iamc_regs.vh"
module iamc_top #(
  parameter integer PWRUP_CYC = `IAMC_PWRUP_CYC,
  parameter integer TIMEOUT_CYC = `IAMC_TIMEOUT_CYC
) (
  // clock and reset
  input wire clk_sys_in,
  input wire srst_in,
  // two-wire bus
  input wire scl_in,
  input wire sda_in,
  output reg sda_o_out,
  output reg sda_oe_out,
  // address strap sense
  input wire [1:0] strap_sel_in,
  // analog core
  input wire conv_done_in,
  input wire [15:0] conv_data_in,
  output reg core_pwr_out,
  output reg conv_start_out,
  output reg cont_mode_out
);
  localparam [4:0] S_IDLE = 5'h01;
  localparam [4:0] S_RX = 5'h02;
  localparam [4:0] S_ACK = 5'h04;
  localparam [4:0] S_TX = 5'h08;
  localparam [4:0] S_MACK = 5'h10;

  localparam [2:0] C_DOWN = 3'h1;
  localparam [2:0] C_WAKE = 3'h2;
  localparam [2:0] C_CONV = 3'h4;

  wire [1:0] bus_f;
  wire [1:0] strap_f;
  wire scl_f;
  wire sda_f;
  reg scl_q_r;
  reg sda_q_r;
  wire scl_rise;
  wire scl_fall;
  wire start_det;
  wire stop_det;
  wire timed_out;
  wire [6:0] own_addr;

  reg [4:0] st_r;
  reg [3:0] bit_cnt_r;
  reg [2:0] byte_idx_r;
  reg rw_r;
  reg gc_r;
  reg [7:0] shift_r;
  reg [7:0] msb_r;
  reg [1:0] ptr_r;
  reg tx_lsb_r;
  reg mack_r;
  reg [15:0] rd_hold_r;
  reg [31:0] to_cnt_r;
  reg wr_stb_r;
  reg [15:0] wr_dat_r;
  reg gc_rst_r;

  reg [14:0] cfg_r;
  reg start_r;
  reg [15:0] lo_r;
  reg [15:0] hi_r;
  reg [15:0] conv_r;
  reg [2:0] c_st_r;
  reg [31:0] pw_cnt_r;

  wire addr_hit;
  wire gc_hit;
  wire ack_ok;
  wire single_mode;
  wire os_go;
  reg [15:0] rd_word;

  // bus and strap pins pass the three-stage filter
  iamc_sync #(
    .W(2),
    .RST(2'h3)
  ) u_bus_sync (
    .clk_sys_in(clk_sys_in),
    .srst_in(srst_in),
    .d_in({scl_in, sda_in}),
    .q_out(bus_f)
  );

  iamc_sync #(
    .W(2),
    .RST(2'h0)
  ) u_strap_sync (
    .clk_sys_in(clk_sys_in),
    .srst_in(srst_in),
    .d_in(strap_sel_in),
    .q_out(strap_f)
  );

  assign scl_f = bus_f[1];
  assign sda_f = bus_f[0];
  assign scl_rise = scl_f & ~scl_q_r;
  assign scl_fall = ~scl_f & scl_q_r;
  assign start_det = scl_f & scl_q_r & sda_q_r & ~sda_f;
  assign stop_det = scl_f & scl_q_r & ~sda_q_r & sda_f;
  assign timed_out = (to_cnt_r >= TIMEOUT_CYC);
  assign own_addr = {`IAMC_ADDR_HI, strap_f};

  assign addr_hit = (byte_idx_r == 3'h0) && (shift_r[7:1] == own_addr);
  assign gc_hit = (byte_idx_r == 3'h0) && (shift_r == {`IAMC_GC_ADDR, 1'b0});
  // after a general call only the command byte is acknowledged
  assign ack_ok = addr_hit | gc_hit |
                  ((byte_idx_r != 3'h0) & (~gc_r | (byte_idx_r == 3'h1)));

  assign single_mode = cfg_r[`IAMC_CFG_MODE];
  assign os_go = (c_st_r == C_DOWN) & (start_r | ~single_mode);

  always @* begin
    case (ptr_r)
      `IAMC_PTR_CONV: rd_word = conv_r;
      `IAMC_PTR_CFG: rd_word = {start_r, cfg_r};
      `IAMC_PTR_LO: rd_word = lo_r;
      `IAMC_PTR_HI: rd_word = hi_r;
      default: rd_word = conv_r;
    endcase
  end

  // bus protocol engine
  always @(posedge clk_sys_in) begin
    if (srst_in) begin
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
      st_r <= S_IDLE;
      bit_cnt_r <= 4'h0;
      byte_idx_r <= 3'h0;
      rw_r <= 1'b0;
      gc_r <= 1'b0;
      shift_r <= 8'h00;
      msb_r <= 8'h00;
      ptr_r <= `IAMC_PTR_CONV;
      tx_lsb_r <= 1'b0;
      mack_r <= 1'b0;
      rd_hold_r <= 16'h0000;
      to_cnt_r <= 32'h0;
      wr_stb_r <= 1'b0;
      wr_dat_r <= 16'h0000;
      gc_rst_r <= 1'b0;
      sda_oe_out <= 1'b0;
      sda_o_out <= 1'b0;
    end else begin
      scl_q_r <= scl_f;
      sda_q_r <= sda_f;
      wr_stb_r <= 1'b0;
      gc_rst_r <= 1'b0;
      sda_o_out <= 1'b0;
      if (start_det) begin
        st_r <= S_RX;
        bit_cnt_r <= 4'h0;
        byte_idx_r <= 3'h0;
        gc_r <= 1'b0;
        tx_lsb_r <= 1'b0;
        sda_oe_out <= 1'b0;
        to_cnt_r <= 32'h0;
      end else if (stop_det || timed_out) begin
        st_r <= S_IDLE;
        sda_oe_out <= 1'b0;
        to_cnt_r <= 32'h0;
      end else begin
        if (st_r == S_IDLE || scl_rise || scl_fall) begin
          to_cnt_r <= 32'h0;
        end else begin
          to_cnt_r <= to_cnt_r + 32'h1;
        end
        case (st_r)
          S_IDLE: begin
            sda_oe_out <= 1'b0;
          end
          S_RX: begin
            if (scl_rise) begin
              shift_r <= {shift_r[6:0], sda_f};
              bit_cnt_r <= bit_cnt_r + 4'h1;
            end else if (scl_fall && bit_cnt_r == `IAMC_BYTE_BITS) begin
              if (ack_ok) begin
                sda_oe_out <= 1'b1;
                st_r <= S_ACK;
                if (byte_idx_r != 3'h4) begin
                  byte_idx_r <= byte_idx_r + 3'h1;
                end
              end else begin
                sda_oe_out <= 1'b0;
                st_r <= S_IDLE;
              end
              if (byte_idx_r == 3'h0) begin
                rw_r <= shift_r[0] & ~gc_hit;
                gc_r <= gc_hit;
              end else if (byte_idx_r == 3'h1) begin
                if (gc_r) begin
                  gc_rst_r <= (shift_r == `IAMC_GC_RESET);
                end else begin
                  ptr_r <= shift_r[1:0];
                end
              end else if (byte_idx_r == 3'h2) begin
                msb_r <= shift_r;
              end else if (byte_idx_r == 3'h3) begin
                wr_stb_r <= 1'b1;
                wr_dat_r <= {msb_r, shift_r};
              end
            end
          end
          S_ACK: begin
            if (scl_fall) begin
              bit_cnt_r <= 4'h0;
              if (rw_r) begin
                rd_hold_r <= rd_word;
                shift_r <= rd_word[15:8];
                sda_oe_out <= ~rd_word[15];
                tx_lsb_r <= 1'b0;
                st_r <= S_TX;
              end else begin
                sda_oe_out <= 1'b0;
                st_r <= S_RX;
              end
            end
          end
          S_TX: begin
            if (scl_rise) begin
              bit_cnt_r <= bit_cnt_r + 4'h1;
            end else if (scl_fall) begin
              if (bit_cnt_r == `IAMC_BYTE_BITS) begin
                sda_oe_out <= 1'b0;
                tx_lsb_r <= ~tx_lsb_r;
                st_r <= S_MACK;
              end else begin
                shift_r <= {shift_r[6:0], 1'b0};
                sda_oe_out <= ~shift_r[6];
              end
            end
          end
          S_MACK: begin
            if (scl_rise) begin
              mack_r <= ~sda_f;
            end else if (scl_fall) begin
              bit_cnt_r <= 4'h0;
              if (mack_r) begin
                st_r <= S_TX;
                if (tx_lsb_r) begin
                  shift_r <= rd_hold_r[7:0];
                  sda_oe_out <= ~rd_hold_r[7];
                end else begin
                  rd_hold_r <= rd_word;
                  shift_r <= rd_word[15:8];
                  sda_oe_out <= ~rd_word[15];
                end
              end else begin
                sda_oe_out <= 1'b0;
                st_r <= S_IDLE;
              end
            end
          end
          default: begin
            st_r <= S_IDLE;
            sda_oe_out <= 1'b0;
          end
        endcase
      end
    end
  end

  // register file, cleared by power-up or general call reset
  always @(posedge clk_sys_in) begin
    if (srst_in || gc_rst_r) begin
      cfg_r <= `IAMC_CFG_RST;
      start_r <= 1'b0;
      lo_r <= `IAMC_LO_RST;
      hi_r <= `IAMC_HI_RST;
      conv_r <= `IAMC_CONV_RST;
    end else begin
      if (wr_stb_r && ptr_r == `IAMC_PTR_CFG) begin
        cfg_r <= wr_dat_r[14:0];
      end
      if (wr_stb_r && ptr_r == `IAMC_PTR_LO) begin
        lo_r <= wr_dat_r;
      end
      if (wr_stb_r && ptr_r == `IAMC_PTR_HI) begin
        hi_r <= wr_dat_r;
      end
      // a start write landing on the clearing cycle is kept
      if (wr_stb_r && ptr_r == `IAMC_PTR_CFG && wr_dat_r[`IAMC_CFG_START] &&
          c_st_r == C_DOWN) begin
        start_r <= 1'b1;
      end else if (os_go) begin
        start_r <= 1'b0;
      end
      if (c_st_r == C_CONV && conv_done_in) begin
        conv_r <= conv_data_in;
      end
    end
  end

  // conversion sequencer
  always @(posedge clk_sys_in) begin
    if (srst_in || gc_rst_r) begin
      c_st_r <= C_DOWN;
      pw_cnt_r <= 32'h0;
      core_pwr_out <= 1'b0;
      conv_start_out <= 1'b0;
      cont_mode_out <= 1'b0;
    end else begin
      conv_start_out <= 1'b0;
      cont_mode_out <= ~single_mode;
      case (c_st_r)
        C_DOWN: begin
          pw_cnt_r <= 32'h0;
          if (os_go) begin
            core_pwr_out <= 1'b1;
            c_st_r <= C_WAKE;
          end else begin
            core_pwr_out <= 1'b0;
          end
        end
        C_WAKE: begin
          core_pwr_out <= 1'b1;
          if (pw_cnt_r >= PWRUP_CYC - 1) begin
            conv_start_out <= 1'b1;
            c_st_r <= C_CONV;
          end else begin
            pw_cnt_r <= pw_cnt_r + 32'h1;
          end
        end
        C_CONV: begin
          core_pwr_out <= 1'b1;
          if (conv_done_in) begin
            if (single_mode) begin
              core_pwr_out <= 1'b0;
              c_st_r <= C_DOWN;
            end else begin
              conv_start_out <= 1'b1;
            end
          end
        end
        default: begin
          c_st_r <= C_DOWN;
          core_pwr_out <= 1'b0;
        end
      endcase
    end
  end
endmodule // iamc_top

// *** verilog/iamc_regs.vh ***
// Purpose: constants for the two-wire slave and conversion-mode control
// Assumes: 250 MHz system clock, strap code already sensed as two bits
// Notes: times kept in their own unit, cycle counts derived from them
//
// Notes on behaviour
// - power-up loads defaults, then sits powered down
// - ack general call address with write bit
// - general call 06h resets like power-up
// - mode bit: 1 single-shot, 0 continuous
// - powered down until start bit written 1; writing mode 0 powers up without it
// - start: wake 25 us, clear bit, convert once
// - start write ignored while conversion runs
// - continuous: store result, restart at once
// - leave continuous on mode 1 or reset
// - slave only: never drive clock, pull low only
// - eight-bit bytes, sample on clock high
// - bus static over 25 ms aborts transaction
// - sda fall/rise with scl high: start/stop
// - answer only matching 7-bit address
// - receiver pulls sda low to acknowledge
// - released sda means not-acknowledge
// - repeated start begins anew, stop idles bus
// - strap picks address 1001000 to 1001011
// - strap sampled continuously, not latched once
// - first write byte loads two-bit pointer
// - sixteen-bit words travel msb byte first
`ifndef IAMC_REGS_VH
`define IAMC_REGS_VH

`define IAMC_ADDR_HI 5'h12
`define IAMC_GC_ADDR 7'h00
`define IAMC_GC_RESET 8'h06
`define IAMC_BYTE_BITS 4'h8

`define IAMC_PTR_CONV 2'h0
`define IAMC_PTR_CFG 2'h1
`define IAMC_PTR_LO 2'h2
`define IAMC_PTR_HI 2'h3

`define IAMC_CFG_RST 15'h0100
`define IAMC_CFG_MODE 8
`define IAMC_CFG_START 15
`define IAMC_CONV_RST 16'h0000
`define IAMC_LO_RST 16'h8000
`define IAMC_HI_RST 16'h7FF0

`define IAMC_CLK_PS 4000
`define IAMC_PWRUP_US 25
`define IAMC_TIMEOUT_MS 25
`define IAMC_PWRUP_CYC ((`IAMC_PWRUP_US * 1000000) / `IAMC_CLK_PS)
`define IAMC_CLK_NS (`IAMC_CLK_PS / 1000)
`define IAMC_TIMEOUT_CYC ((`IAMC_TIMEOUT_MS * 1000000 + `IAMC_CLK_NS - 1) / `IAMC_CLK_NS)

`endif

// *** verilog/iamc_sync.v ***
// Purpose: three-stage input synchroniser with agreement filter
// Assumes: inputs asynchronous to clk_sys_in
// Notes: output follows once stages two and three agree
`timescale 1ns/1ps
module iamc_sync #(
  parameter W = 1,
  parameter [W-1:0] RST = {W{1'b0}}
) (
  // clock and reset
  input wire clk_sys_in,
  input wire srst_in,
  // data
  input wire [W-1:0] d_in,
  output reg [W-1:0] q_out
);
  reg [W-1:0] s1_r;
  reg [W-1:0] s2_r;
  reg [W-1:0] s3_r;
  integer i;

  always @(posedge clk_sys_in) begin
    if (srst_in) begin
      s1_r <= RST;
      s2_r <= RST;
      s3_r <= RST;
      q_out <= RST;
    end else begin
      s1_r <= d_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      for (i = 0; i < W; i = i + 1) begin
        if (s2_r[i] == s3_r[i]) begin
          q_out[i] <= s3_r[i];
        end
      end
    end
  end
endmodule // iamc_sync

// *** verification/iamc_top_sva.sv ***
// Purpose: port checker for iamc_top
// Assumes: PWRUP_CYC under 300
// Notes: bound after endmodule
`timescale 1ns/1ps
module iamc_top_sva #(
  parameter integer PWRUP_CYC = 8,
  parameter integer TIMEOUT_CYC = 2000
) (
  // clock and reset
  input wire clk_sys_in,
  input wire srst_in,
  // bus
  input wire scl_in,
  input wire sda_in,
  input wire sda_o_out,
  input wire sda_oe_out,
  // core
  input wire conv_done_in,
  input wire core_pwr_out,
  input wire conv_start_out,
  input wire cont_mode_out
);
  reg busy_r;
  reg scl_r;
  reg [31:0] idle_r;
  always @(posedge clk_sys_in) begin
    scl_r <= scl_in;
    if (srst_in || conv_done_in || !core_pwr_out)
      busy_r <= 1'b0;
    else if (conv_start_out)
      busy_r <= 1'b1;
    if (srst_in || scl_in != scl_r)
      idle_r <= 32'h0;
    else if (idle_r <= TIMEOUT_CYC + 8)
      idle_r <= idle_r + 32'h1;
  end
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (srst_in);
  sequence s_wake;
    $rose(core_pwr_out);
  endsequence
  sequence s_fire;
    ##PWRUP_CYC conv_start_out;
  endsequence
  a_pin_low: assert property (sda_o_out == 1'b0)
    else $error("data pin driven high");
  a_wake_delay: assert property (s_wake |-> s_fire)
    else $error("start not at wake delay");
  a_cont_next: assert property (cont_mode_out && conv_done_in |=> conv_start_out)
    else $error("no restart");
  a_single_off: assert property (!cont_mode_out && conv_done_in && core_pwr_out
    |=> !core_pwr_out)
    else $error("no power down");
  a_single_once: assert property (busy_r && !cont_mode_out |-> !conv_start_out)
    else $error("second start");
  a_reset_quiet: assert property (disable iff (1'b0)
    srst_in |=> !core_pwr_out && !cont_mode_out && !sda_oe_out)
    else $error("outputs active after reset");
  a_oe_scl_low: assert property ($changed(sda_oe_out) |-> !scl_in)
    else $error("data moved with clock high");
  a_stop_free: assert property ($rose(sda_in) && scl_in && $past(scl_in)
    |-> !sda_oe_out [*8])
    else $error("data held after stop");
  a_idle_free: assert property (idle_r > TIMEOUT_CYC + 8 |-> !sda_oe_out)
    else $error("data held after timeout");
endmodule // iamc_top_sva
bind iamc_top iamc_top_sva #(.PWRUP_CYC(PWRUP_CYC), .TIMEOUT_CYC(TIMEOUT_CYC)) i_iamc_top_sva (
  .clk_sys_in, .srst_in, .scl_in, .sda_in, .sda_o_out, .sda_oe_out,
  .conv_done_in, .core_pwr_out, .conv_start_out, .cont_mode_out);

// *** verification/iamc_master_model.sv ***
// Purpose: two-wire bus master model
// Assumes: pull-up on data line
// Notes: 125 ns bit time, clock idles high
`timescale 1ns/1ps
module iamc_master_model (
  // bus
  input wire sda_in,
  output reg scl_out,
  output reg sda_low_out
);
  localparam real Q = 31.25;
  initial begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
  end
  task start;
    begin
      sda_low_out = 1'b0;
      #Q scl_out = 1'b1;
      #Q sda_low_out = 1'b1;
      #Q scl_out = 1'b0;
    end
  endtask
  task stop;
    begin
      #Q sda_low_out = 1'b1;
      #Q scl_out = 1'b1;
      #Q sda_low_out = 1'b0;
      #Q;
    end
  endtask
  // eight bits then the answer slot, data moved only with clock low
  // strap is a sensed code here, so a plain quarter-bit (Q) data-line hold after clock fall
  task xfer(input [8:0] tx, output [8:0] rx);
    integer i;
    begin
      for (i = 8; i >= 0; i = i - 1) begin
        #Q sda_low_out = !tx[i];
        #Q scl_out = 1'b1;
        #Q rx[i] = sda_in;
        #Q scl_out = 1'b0;
      end
    end
  endtask
endmodule // iamc_master_model

// *** verification/test_i2c_adc_mode_control.sv ***
// Purpose: self-checking bench for iamc_top
// Assumes: short wake and timeout counts
// Notes: bus traffic from the master model
`timescale 1ns/1ps
module test_i2c_adc_mode_control;
  localparam integer PW = 8;
  reg clk_sys_in = 1'b0;
  reg srst_in = 1'b1;
  reg [1:0] strap_sel_in = 2'h0;
  reg conv_done_in = 1'b0;
  reg [15:0] conv_data_in = 16'h0000;
  wire scl_w, sda_low_w, sda_o_w, sda_oe_w, pwr_w, start_w, cont_w;
  wire sda_w = !(sda_low_w || sda_oe_w);
  integer n_errors = 0;
  integer compares = 0;
  reg [15:0] n_starts = 16'h0000;
  reg [15:0] n;
  reg [8:0] rx;
  reg [15:0] v;
  always #2 clk_sys_in = ~clk_sys_in;
  always @(posedge clk_sys_in) if (start_w === 1'b1) n_starts <= n_starts + 16'h1;
  iamc_top #(.PWRUP_CYC(PW), .TIMEOUT_CYC(2000)) i_iamc_top (
    .clk_sys_in(clk_sys_in), .srst_in(srst_in), .scl_in(scl_w), .sda_in(sda_w),
    .sda_o_out(sda_o_w), .sda_oe_out(sda_oe_w), .strap_sel_in(strap_sel_in),
    .conv_done_in(conv_done_in), .conv_data_in(conv_data_in),
    .core_pwr_out(pwr_w), .conv_start_out(start_w), .cont_mode_out(cont_w));
  iamc_master_model i_iamc_master_model (.sda_in(sda_w), .scl_out(scl_w), .sda_low_out(sda_low_w));
  task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    begin
      compares = compares + 1;
      if (seen !== exp) begin
        n_errors = n_errors + 1;
        $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
    end
  endtask
  task summarize;
    begin
      $display("compares %0d mismatches %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask
  task ack(input [7:0] b, input logic exp);
    begin
      i_iamc_master_model.xfer({b, 1'b1}, rx);
      check("ack", {15'h0, !rx[0]}, {15'h0, exp});
    end
  endtask
  task wr(input [1:0] p, input [15:0] d);
    begin
      i_iamc_master_model.start;
      ack({5'h12, strap_sel_in, 1'b0}, 1'b1);
      ack({6'h00, p}, 1'b1);
      ack(d[15:8], 1'b1);
      ack(d[7:0], 1'b1);
      i_iamc_master_model.stop;
    end
  endtask
  task rd(input [1:0] p, input [15:0] exp);
    begin
      i_iamc_master_model.start;
      ack({5'h12, strap_sel_in, 1'b0}, 1'b1);
      ack({6'h00, p}, 1'b1);
      i_iamc_master_model.start;
      ack({5'h12, strap_sel_in, 1'b1}, 1'b1);
      i_iamc_master_model.xfer(9'h1FE, rx);
      v[15:8] = rx[8:1];
      i_iamc_master_model.xfer(9'h1FF, rx);
      v[7:0] = rx[8:1];
      i_iamc_master_model.stop;
      check("register", v, exp);
    end
  endtask
  task wait_pwr(input logic lvl);
    integer i;
    begin
      for (i = 0; i < 100 && pwr_w !== lvl; i = i + 1)
        @(posedge clk_sys_in);
      check("power", {15'h0, pwr_w}, {15'h0, lvl});
      if (pwr_w !== lvl)
        summarize;
    end
  endtask
  task done(input [15:0] d);
    begin
      @(posedge clk_sys_in);
      conv_done_in <= 1'b1;
      conv_data_in <= d;
      @(posedge clk_sys_in);
      conv_done_in <= 1'b0;
    end
  endtask
  task t_regs;
    begin
      check("idle", {14'h0, pwr_w, cont_w}, 16'h0000);
      rd(2'h0, 16'h0000);
      rd(2'h1, 16'h0100);
      rd(2'h2, 16'h8000);
      rd(2'h3, 16'h7FF0);
      $display("t_regs done");
    end
  endtask
  task t_addr;
    integer s;
    begin
      for (s = 0; s < 4; s = s + 1) begin
        @(posedge clk_sys_in);
        strap_sel_in <= s[1:0];
        repeat (8) @(posedge clk_sys_in);
        i_iamc_master_model.start;
        ack({5'h12, s[1:0], 1'b0}, 1'b1);
        i_iamc_master_model.stop;
        i_iamc_master_model.start;
        ack({5'h12, s[1:0] ^ 2'h1, 1'b0}, 1'b0);
        i_iamc_master_model.stop;
      end
      $display("t_addr done");
    end
  endtask
  task t_single;
    begin
      n = n_starts;
      wr(2'h1, 16'h8100);
      wait_pwr(1'b1);
      repeat (PW + 4) @(posedge clk_sys_in);
      check("starts", n_starts - n, 16'h0001);
      wr(2'h1, 16'h8100);
      check("starts", n_starts - n, 16'h0001);
      rd(2'h1, 16'h0100);
      done(16'h1230);
      wait_pwr(1'b0);
      rd(2'h0, 16'h1230);
      check("starts", n_starts - n, 16'h0001);
      $display("t_single done");
    end
  endtask
  task t_cont;
    begin
      wr(2'h1, 16'h8000);
      wait_pwr(1'b1);
      check("mode", {15'h0, cont_w}, 16'h0001);
      repeat (PW + 4) @(posedge clk_sys_in);
      n = n_starts;
      done(16'hABC0);
      repeat (3) @(posedge clk_sys_in);
      check("restart", n_starts - n, 16'h0001);
      rd(2'h0, 16'hABC0);
      i_iamc_master_model.start;
      ack(8'h00, 1'b1);
      ack(8'h06, 1'b1);
      i_iamc_master_model.stop;
      wait_pwr(1'b0);
      check("mode", {15'h0, cont_w}, 16'h0000);
      rd(2'h1, 16'h0100);
      $display("t_cont done");
    end
  endtask
  task t_timeout;
    begin
      i_iamc_master_model.start;
      ack({5'h12, strap_sel_in, 1'b1}, 1'b1);
      repeat (10) @(posedge clk_sys_in);
      check("drive", {15'h0, sda_oe_w}, 16'h0001);
      repeat (2100) @(posedge clk_sys_in);
      check("release", {15'h0, sda_oe_w}, 16'h0000);
      i_iamc_master_model.stop;
      rd(2'h2, 16'h8000);
      $display("t_timeout done");
    end
  endtask
  initial begin
    repeat (3) @(posedge clk_sys_in);
    srst_in <= 1'b0;
    repeat (8) @(posedge clk_sys_in);
    t_regs;
    t_addr;
    t_single;
    t_cont;
    t_timeout;
    summarize;
  end
endmodule // test_i2c_adc_mode_control
